// >>> core/rcf_pkg.sv
// shared constants for the remote command response framer
package rcf_pkg;
	// frame markers and types
	localparam logic [7:0]  START_MARK     = 8'h7e;
	localparam logic [7:0]  TYPE_REQ       = 8'h17;
	localparam logic [7:0]  TYPE_RSP       = 8'h97;
	localparam logic [7:0]  CKS_BASE       = 8'hff;
	// byte offsets inside a response frame
	localparam logic [4:0]  OFS_LEN_HI     = 5'h01;
	localparam logic [4:0]  OFS_LEN_LO     = 5'h02;
	localparam logic [4:0]  OFS_TYPE       = 5'h03;
	localparam logic [4:0]  OFS_FID        = 5'h04;
	localparam logic [4:0]  OFS_A64        = 5'h05;
	localparam logic [4:0]  OFS_A64_END    = 5'h0c;
	localparam logic [4:0]  OFS_A16        = 5'h0d;
	localparam logic [4:0]  OFS_CMD        = 5'h0f;
	localparam logic [4:0]  OFS_STATUS     = 5'h11;
	localparam logic [4:0]  OFS_VAL        = 5'h12;
	// bytes from type through status
	localparam logic [15:0] LEN_FIXED      = 16'h000f;
	localparam int          VAL_BYTES      = 4;
	// status codes
	localparam logic [7:0]  ST_OK          = 8'h00;
	localparam logic [7:0]  ST_ERROR       = 8'h01;
	localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
	localparam logic [7:0]  ST_BAD_PARAM   = 8'h03;
	localparam logic [7:0]  ST_TX_FAIL     = 8'h04;
	localparam logic [7:0]  ST_NO_SESSION  = 8'h0b;
	localparam logic [7:0]  ST_CRYPT_ERR   = 8'h0c;
	localparam logic [7:0]  ST_INSECURE    = 8'h0d;
	// two-character commands handled by the node
	localparam logic [15:0] CMD_SERIAL_BAUD = 16'h4244;
	localparam logic [15:0] APPLY_CHANGES_CMD = 16'h4143;
	localparam logic [15:0] SAVE_CMD       = 16'h5752;
	localparam logic [15:0] SOFTWARE_RESET_CMD = 16'h4652;
	localparam int          OPT_APPLY_BIT  = 1;
	localparam logic [15:0] A16_UNKNOWN    = 16'hfffe;
	localparam logic [31:0] BAUD_RESET     = 32'h00000003;
	// host register map
	localparam logic [7:0]  REG_ADDR_HI    = 8'h00;
	localparam logic [7:0]  REG_ADDR_LO    = 8'h04;
	localparam logic [7:0]  REG_CMD        = 8'h08;
	localparam logic [7:0]  REG_PARAM      = 8'h0c;
	localparam logic [7:0]  REG_GO         = 8'h10;
	localparam logic [7:0]  REG_RSP_INFO   = 8'h14;
	localparam logic [7:0]  REG_RSP_VAL    = 8'h18;
	localparam logic [7:0]  REG_IRQ_STAT   = 8'h1c;
	localparam logic [7:0]  REG_IRQ_EN     = 8'h20;
	localparam logic [7:0]  REG_IRQ_CLR    = 8'h24;
	localparam int          IRQ_RSP_OK     = 0;
	localparam int          IRQ_RSP_FAIL   = 1;
	localparam int          IRQ_CKS_ERR    = 2;
	localparam int          IRQ_W          = 3;
endpackage : rcf_pkg

// >>> core/rcf_link_if.sv
// link between the serial host and the local radio device
`timescale 1ns/1ps
`default_nettype none
interface rcf_link_if;
	logic        req_valid;   // one-cycle request pulse
	logic [7:0]  req_fid;
	logic [63:0] req_addr64;
	logic [7:0]  req_opt;
	logic [15:0] req_cmd;
	logic        req_has_param;
	logic [31:0] req_param;
	logic        tx_valid;    // one byte of response frame
	logic [7:0]  tx_byte;

	modport dev (
		input  req_valid, req_fid, req_addr64, req_opt, req_cmd,
		input  req_has_param, req_param,
		output tx_valid, tx_byte
	);
	modport host (
		output req_valid, req_fid, req_addr64, req_opt, req_cmd,
		output req_has_param, req_param,
		input  tx_valid, tx_byte
	);
endinterface : rcf_link_if
`default_nettype wire

// >>> core/rcf_device.sv
// radio device end: response framer and remote parameter node
// Functional notes
// - parameter change responses omit value field
// - query returns currently configured value
// - checksum is 0xff minus byte sum
// - api mode one sends bytes verbatim
// - remote writes stay pending until applied
// - apply on option, apply cmd, save+reset
// - zero frame identifier suppresses any response; a radio response with fid 0 is still framed
// - received response becomes one serial frame
// - unreachable target never yields success frame
// - host fills request fields correctly
// - response type 0x97, identifier copied
// - host retries on transmission failure
// - fixed field layout through status byte
// - length counts bytes type through value
// - status byte uses defined code set
`timescale 1ns/1ps
`default_nettype none
module rcf_device (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	rcf_link_if.dev          lnk,
	// request forwarded onto the radio
	output logic             fwd_valid_o,
	output logic [63:0]      fwd_addr64_o,
	output logic [7:0]       fwd_fid_o,
	output logic [7:0]       fwd_opt_o,
	output logic [15:0]      fwd_cmd_o,
	output logic             fwd_has_param_o,
	output logic [31:0]      fwd_param_o,
	// response transmission received from the radio
	input  wire logic        rsp_valid_i,
	input  wire logic [7:0]  rsp_fid_i,
	input  wire logic [63:0] rsp_addr64_i,
	input  wire logic [15:0] rsp_addr16_i,
	input  wire logic [15:0] rsp_cmd_i,
	input  wire logic [7:0]  rsp_status_i,
	input  wire logic [31:0] rsp_val_i,
	input  wire logic        unreach_i,
	output logic             rsp_ready_o,
	// request arriving from a far node, this node as target
	input  wire logic        rreq_valid_i,
	input  wire logic [7:0]  rreq_fid_i,
	input  wire logic [7:0]  rreq_opt_i,
	input  wire logic [15:0] rreq_cmd_i,
	input  wire logic        rreq_has_param_i,
	input  wire logic [31:0] rreq_param_i,
	output logic             rrsp_valid_o,
	output logic [7:0]       rrsp_fid_o,
	output logic [7:0]       rrsp_status_o,
	output logic             rrsp_has_val_o,
	output logic [31:0]      rrsp_val_o,
	output logic [31:0]      serial_baud_setting_o
);
	////////////////////////////////////////////////////////////////////////
	// frame byte selection
	function automatic logic [7:0] frame_byte(
		input logic [4:0]  idx,
		input logic [15:0] len,
		input logic [7:0]  fid,
		input logic [63:0] a64,
		input logic [15:0] a16,
		input logic [15:0] cmd,
		input logic [7:0]  st,
		input logic [31:0] val,
		input logic [2:0]  vlen
	);
		logic [63:0] sh64;
		logic [31:0] sh32;
		logic [4:0]  k;
		sh64 = a64 >> {(rcf_pkg::OFS_A64_END - idx), 3'b000};
		k    = idx - rcf_pkg::OFS_VAL;
		sh32 = val >> {(5'({2'b00, vlen}) - 5'h01 - k), 3'b000};
		case (idx)
			5'h00:                 frame_byte = rcf_pkg::START_MARK;
			rcf_pkg::OFS_LEN_HI:   frame_byte = len[15:8];
			rcf_pkg::OFS_LEN_LO:   frame_byte = len[7:0];
			rcf_pkg::OFS_TYPE:     frame_byte = rcf_pkg::TYPE_RSP;
			rcf_pkg::OFS_FID:      frame_byte = fid;
			rcf_pkg::OFS_A16:      frame_byte = a16[15:8];
			rcf_pkg::OFS_A16 + 5'h01: frame_byte = a16[7:0];
			rcf_pkg::OFS_CMD:      frame_byte = cmd[15:8];
			rcf_pkg::OFS_CMD + 5'h01: frame_byte = cmd[7:0];
			rcf_pkg::OFS_STATUS:   frame_byte = st;
			default:
			begin
				// address bytes msb first, then value
				if (idx < rcf_pkg::OFS_A16)
					frame_byte = sh64[7:0];
				else
					frame_byte = sh32[7:0];
			end
		endcase
	endfunction : frame_byte

	////////////////////////////////////////////////////////////////////////
	// forwarding toward the radio, remembering the last request
	logic        last_chg_ff;
	logic [7:0]  last_fid_ff;
	logic [15:0] last_cmd_ff;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fwd_valid_o     <= 1'b0;
			fwd_addr64_o    <= '0;
			fwd_fid_o       <= '0;
			fwd_opt_o       <= '0;
			fwd_cmd_o       <= '0;
			fwd_has_param_o <= 1'b0;
			fwd_param_o     <= '0;
			last_chg_ff     <= 1'b0;
			last_fid_ff     <= '0;
			last_cmd_ff     <= '0;
		end
		else
		begin
			fwd_valid_o <= lnk.req_valid;
			if (lnk.req_valid)
			begin
				fwd_addr64_o    <= lnk.req_addr64;
				fwd_fid_o       <= lnk.req_fid;
				fwd_opt_o       <= lnk.req_opt;
				fwd_cmd_o       <= lnk.req_cmd;
				fwd_has_param_o <= lnk.req_has_param;
				fwd_param_o     <= lnk.req_param;
				last_chg_ff     <= lnk.req_has_param;
				last_fid_ff     <= lnk.req_fid;
				last_cmd_ff     <= lnk.req_cmd;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// response framer toward the host
	logic        busy_ff;
	logic [4:0]  idx_ff;
	logic [7:0]  sum_ff;
	logic [7:0]  f_fid_ff;
	logic [63:0] f_a64_ff;
	logic [15:0] f_a16_ff;
	logic [15:0] f_cmd_ff;
	logic [7:0]  f_st_ff;
	logic [31:0] f_val_ff;
	logic [2:0]  f_vlen_ff;
	logic        tx_valid_ff;
	logic [7:0]  tx_byte_ff;
	logic [15:0] f_len;
	logic [4:0]  last_idx;
	logic        fail_load;

	assign f_len    = rcf_pkg::LEN_FIXED + 16'({13'h0000, f_vlen_ff});
	assign last_idx = rcf_pkg::OFS_VAL + 5'({2'b00, f_vlen_ff});
	// unreachable target yields failure, not success
	assign fail_load = unreach_i && !rsp_valid_i && last_fid_ff != 8'h00;
	// bytes leave verbatim, no escape stage
	assign lnk.tx_valid = tx_valid_ff;
	assign lnk.tx_byte  = tx_byte_ff;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_ff     <= 1'b0;
			idx_ff      <= '0;
			sum_ff      <= '0;
			f_fid_ff    <= '0;
			f_a64_ff    <= '0;
			f_a16_ff    <= '0;
			f_cmd_ff    <= '0;
			f_st_ff     <= '0;
			f_val_ff    <= '0;
			f_vlen_ff   <= '0;
			tx_valid_ff <= 1'b0;
			tx_byte_ff  <= '0;
			rsp_ready_o <= 1'b0;
		end
		else if (!busy_ff)
		begin
			tx_valid_ff <= 1'b0;
			idx_ff      <= '0;
			sum_ff      <= '0;
			rsp_ready_o <= !(rsp_valid_i || fail_load);
			if (rsp_valid_i)
			begin
				busy_ff  <= 1'b1;
				f_fid_ff <= rsp_fid_i;
				f_a64_ff <= rsp_addr64_i;
				f_a16_ff <= rsp_addr16_i;
				f_cmd_ff <= rsp_cmd_i;
				f_st_ff  <= rsp_status_i;
				f_val_ff <= rsp_val_i;
				// change answers carry no value field
				if (last_chg_ff && rsp_fid_i == last_fid_ff)
					f_vlen_ff <= 3'h0;
				else
					f_vlen_ff <= 3'(rcf_pkg::VAL_BYTES);
			end
			else if (fail_load)
			begin
				busy_ff   <= 1'b1;
				f_fid_ff  <= last_fid_ff;
				f_a64_ff  <= fwd_addr64_o;
				f_a16_ff  <= rcf_pkg::A16_UNKNOWN;
				f_cmd_ff  <= last_cmd_ff;
				f_st_ff   <= rcf_pkg::ST_TX_FAIL;
				f_val_ff  <= '0;
				f_vlen_ff <= 3'h0;
			end
		end
		else
		begin
			tx_valid_ff <= 1'b1;
			idx_ff      <= idx_ff + 5'h01;
			// sum from type up to checksum
			if (idx_ff >= rcf_pkg::OFS_TYPE)
				sum_ff <= sum_ff + frame_byte(idx_ff, f_len, f_fid_ff,
					f_a64_ff, f_a16_ff, f_cmd_ff, f_st_ff, f_val_ff,
					f_vlen_ff);
			if (idx_ff == last_idx)
			begin
				tx_byte_ff  <= rcf_pkg::CKS_BASE - sum_ff;
				busy_ff     <= 1'b0;
				rsp_ready_o <= 1'b1;
			end
			else
				tx_byte_ff <= frame_byte(idx_ff, f_len, f_fid_ff,
					f_a64_ff, f_a16_ff, f_cmd_ff, f_st_ff, f_val_ff,
					f_vlen_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// node side: pending and active serial baud setting
	logic [31:0] pend_ff;
	logic        saved_ff;
	logic        is_baud;
	logic        applies;

	assign is_baud = rreq_cmd_i == rcf_pkg::CMD_SERIAL_BAUD;
	assign applies = rreq_opt_i[rcf_pkg::OPT_APPLY_BIT];

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pend_ff               <= rcf_pkg::BAUD_RESET;
			serial_baud_setting_o <= rcf_pkg::BAUD_RESET;
			saved_ff              <= 1'b0;
		end
		else if (rreq_valid_i)
		begin
			// writes always land in the pending copy
			if (is_baud && rreq_has_param_i)
				pend_ff <= rreq_param_i;
			// apply option commits the new value
			if (is_baud && rreq_has_param_i && applies)
				serial_baud_setting_o <= rreq_param_i;
			else if (rreq_cmd_i == rcf_pkg::APPLY_CHANGES_CMD || applies)
				serial_baud_setting_o <= pend_ff;
			if (rreq_cmd_i == rcf_pkg::SAVE_CMD)
				saved_ff <= 1'b1;
			else if (rreq_cmd_i == rcf_pkg::SOFTWARE_RESET_CMD)
			begin
				saved_ff <= 1'b0;
				if (saved_ff)
					serial_baud_setting_o <= pend_ff;
			end
		end
	end

	// answer to the far requester
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rrsp_valid_o   <= 1'b0;
			rrsp_fid_o     <= '0;
			rrsp_status_o  <= '0;
			rrsp_has_val_o <= 1'b0;
			rrsp_val_o     <= '0;
		end
		else
		begin
			rrsp_valid_o   <= rreq_valid_i && rreq_fid_i != 8'h00;
			rrsp_fid_o     <= rreq_fid_i;
			rrsp_has_val_o <= is_baud && !rreq_has_param_i;
			rrsp_val_o     <= serial_baud_setting_o;
			// status from the defined code set
			if (is_baud || rreq_cmd_i == rcf_pkg::APPLY_CHANGES_CMD
				|| rreq_cmd_i == rcf_pkg::SAVE_CMD
				|| rreq_cmd_i == rcf_pkg::SOFTWARE_RESET_CMD)
				rrsp_status_o <= rcf_pkg::ST_OK;
			else
				rrsp_status_o <= rcf_pkg::ST_BAD_CMD;
		end
	end
endmodule : rcf_device
`default_nettype wire

// >>> core/rcf_host.sv
// serial host end: request launcher and response frame parser
`timescale 1ns/1ps
`default_nettype none
module rcf_host (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	rcf_link_if.host        lnk,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic       reg_we_i,
	input  wire logic       reg_re_i,
	output logic [31:0]     reg_rdata_o,
	output logic            irq_o
);
	typedef enum {HUNT, LEN_HI, LEN_LO, BODY, CKS} rcf_pst_t;

	logic [31:0] a_hi_ff, a_lo_ff, cmd_ff, param_ff;
	logic [31:0] info_ff, val_ff;
	logic [rcf_pkg::IRQ_W-1:0] stat_ff, en_ff, ev;
	rcf_pst_t    st_ff;
	logic [15:0] left_ff;
	logic [4:0]  pos_ff;
	logic [7:0]  sum_ff, ty_ff, fid_ff, sts_ff;
	logic [15:0] rcmd_ff;
	logic [31:0] rval_ff;
	logic        retry, go;
	logic [7:0]  b;

	assign b  = lnk.tx_byte;
	assign go = reg_we_i && reg_addr_i == rcf_pkg::REG_GO;

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			a_hi_ff <= '0;
			a_lo_ff <= '0;
			cmd_ff <= '0;
			param_ff <= '0;
			en_ff <= '0;
		end
		else if (reg_we_i)
		begin
			case (reg_addr_i)
				rcf_pkg::REG_ADDR_HI: a_hi_ff  <= reg_wdata_i;
				rcf_pkg::REG_ADDR_LO: a_lo_ff  <= reg_wdata_i;
				rcf_pkg::REG_CMD:     cmd_ff   <= reg_wdata_i;
				rcf_pkg::REG_PARAM:   param_ff <= reg_wdata_i;
				rcf_pkg::REG_IRQ_EN:  en_ff <= reg_wdata_i[rcf_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// read port, data one cycle after the strobe
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= '0;
		else if (reg_re_i)
		begin
			case (reg_addr_i)
				rcf_pkg::REG_ADDR_HI:  reg_rdata_o <= a_hi_ff;
				rcf_pkg::REG_ADDR_LO:  reg_rdata_o <= a_lo_ff;
				rcf_pkg::REG_CMD:      reg_rdata_o <= cmd_ff;
				rcf_pkg::REG_PARAM:    reg_rdata_o <= param_ff;
				rcf_pkg::REG_RSP_INFO: reg_rdata_o <= info_ff;
				rcf_pkg::REG_RSP_VAL:  reg_rdata_o <= val_ff;
				rcf_pkg::REG_IRQ_STAT: reg_rdata_o <= 32'(stat_ff);
				rcf_pkg::REG_IRQ_EN:   reg_rdata_o <= 32'(en_ff);
				default:               reg_rdata_o <= '0;
			endcase
		end
		else
			reg_rdata_o <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// request launch; type 0x17 fields from registers
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lnk.req_valid <= 1'b0;
			lnk.req_fid <= '0;
			lnk.req_addr64 <= '0;
			lnk.req_opt <= '0;
			lnk.req_cmd <= '0;
			lnk.req_has_param <= 1'b0;
			lnk.req_param <= '0;
		end
		else
		begin
			lnk.req_valid <= (go && reg_wdata_i[0]) || retry;
			if (go && reg_wdata_i[0])
			begin
				lnk.req_fid <= cmd_ff[31:24];
				lnk.req_addr64 <= {a_hi_ff, a_lo_ff};
				lnk.req_opt <= cmd_ff[23:16];
				lnk.req_cmd <= cmd_ff[15:0];
				lnk.req_has_param <= reg_wdata_i[1];
				lnk.req_param <= param_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame parser
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_ff <= HUNT;
			left_ff <= '0;
			pos_ff <= '0;
			sum_ff <= '0;
			ty_ff <= '0;
			fid_ff <= '0;
			sts_ff <= '0;
			rcmd_ff <= '0;
			rval_ff <= '0;
		end
		else if (lnk.tx_valid)
		begin
			case (st_ff)
				// skip bytes until the start marker
				HUNT: if (b == rcf_pkg::START_MARK) st_ff <= LEN_HI;
				LEN_HI:
				begin
					left_ff[15:8] <= b;
					st_ff <= LEN_LO;
				end
				LEN_LO:
				begin
					left_ff[7:0] <= b;
					pos_ff <= rcf_pkg::OFS_TYPE;
					sum_ff <= '0;
					rval_ff <= '0;
					st_ff <= BODY;
				end
				BODY:
				begin
					sum_ff <= sum_ff + b;
					left_ff <= left_ff - 16'h0001;
					if (pos_ff != 5'h1f)
						pos_ff <= pos_ff + 5'h01;
					if (pos_ff == rcf_pkg::OFS_TYPE) ty_ff <= b;
					if (pos_ff == rcf_pkg::OFS_FID) fid_ff <= b;
					if (pos_ff == rcf_pkg::OFS_CMD) rcmd_ff[15:8] <= b;
					if (pos_ff == rcf_pkg::OFS_CMD + 5'h01)
						rcmd_ff[7:0] <= b;
					if (pos_ff == rcf_pkg::OFS_STATUS) sts_ff <= b;
					if (pos_ff >= rcf_pkg::OFS_VAL)
						rval_ff <= {rval_ff[23:0], b};
					if (left_ff == 16'h0001) st_ff <= CKS;
				end
				CKS: st_ff <= HUNT;
				default: st_ff <= HUNT;
			endcase
		end
	end

	// checksum check on the last byte
	always_comb
	begin
		ev = '0;
		retry = 1'b0;
		if (lnk.tx_valid && st_ff == CKS)
		begin
			if (b != rcf_pkg::CKS_BASE - sum_ff
				|| ty_ff != rcf_pkg::TYPE_RSP)
				ev[rcf_pkg::IRQ_CKS_ERR] = 1'b1;
			else if (sts_ff == rcf_pkg::ST_TX_FAIL)
			begin
				ev[rcf_pkg::IRQ_RSP_FAIL] = 1'b1;
				retry = 1'b1;
			end
			else
				ev[rcf_pkg::IRQ_RSP_OK] = 1'b1;
		end
	end

	// response capture, sticky status, interrupt; set beats clear
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			info_ff <= '0;
			val_ff <= '0;
			stat_ff <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			if (ev != '0 && !ev[rcf_pkg::IRQ_CKS_ERR])
			begin
				info_ff <= {fid_ff, sts_ff, rcmd_ff};
				val_ff <= rval_ff;
			end
			if (reg_we_i && reg_addr_i == rcf_pkg::REG_IRQ_CLR)
				stat_ff <= (stat_ff & ~reg_wdata_i[rcf_pkg::IRQ_W-1:0])
					| ev;
			else
				stat_ff <= stat_ff | ev;
			irq_o <= |(stat_ff & en_ff);
		end
	end
endmodule : rcf_host
`default_nettype wire

// >>> dv/rcf_link_sva.sv
// assertion checker watching the host-device link
`timescale 1ns/1ps
`default_nettype none
module rcf_link_sva (
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       req_valid,
	input wire logic [7:0] req_fid,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_byte
);
	logic [4:0] idx_ff;
	logic [7:0] len_ff;
	logic [7:0] sum_ff;
	logic [7:0] fid_ff;
	logic [7:0] st_ff;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////
	// byte index, sum from offset 3; fid and status kept for retry
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			idx_ff <= 5'h00;
			len_ff <= 8'h00;
			sum_ff <= 8'h00;
			fid_ff <= 8'h00;
			st_ff  <= 8'h00;
		end
		else if (!tx_valid)
		begin
			idx_ff <= 5'h00;
			sum_ff <= 8'h00;
		end
		else
		begin
			idx_ff <= idx_ff + 5'h01;
			if (idx_ff >= 5'h03)
				sum_ff <= sum_ff + tx_byte;
			if (idx_ff == 5'h02)
				len_ff <= tx_byte;
			if (idx_ff == rcf_pkg::OFS_FID)
				fid_ff <= tx_byte;
			if (idx_ff == rcf_pkg::OFS_STATUS)
				st_ff <= tx_byte;
		end
	end

	////////////////////////////////////////////////////////////
	// frame opening and closing steps
	sequence frame_open;
		$rose(tx_valid) ##1 tx_valid;
	endsequence
	sequence frame_end;
		$fell(tx_valid);
	endsequence

	start_mark_a : assert property (
		$rose(tx_valid) |-> tx_byte == rcf_pkg::START_MARK)
		else $error("frame opens without start marker");
	len_hi_a : assert property (
		frame_open |-> tx_byte == 8'h00)
		else $error("length high byte not zero");
	len_lo_a : assert property (
		frame_open ##1 tx_valid |-> tx_byte inside {8'h0f, 8'h13})
		else $error("length low byte of unknown size");
	type_byte_a : assert property (
		frame_open ##1 tx_valid [*2] |-> tx_byte == rcf_pkg::TYPE_RSP)
		else $error("frame type byte wrong");
	frame_len_a : assert property (
		frame_end |-> {3'h0, idx_ff} == len_ff + 8'h04)
		else $error("frame byte count disagrees with length");
	frame_cks_a : assert property (
		frame_end |-> sum_ff == rcf_pkg::CKS_BASE)
		else $error("frame checksum wrong");
	status_code_a : assert property (
		frame_end |-> st_ff inside {8'h00, 8'h01, 8'h02, 8'h03,
			8'h04, 8'h0b, 8'h0c, 8'h0d})
		else $error("status byte outside code set");
	retry_req_a : assert property (
		$fell(tx_valid) && st_ff == rcf_pkg::ST_TX_FAIL
		|-> ##[0:2] (req_valid && req_fid == fid_ff))
		else $error("failed request not reissued");
	req_pulse_a : assert property (
		req_valid |=> !req_valid)
		else $error("request pulse longer than one cycle");
endmodule : rcf_link_sva
`default_nettype wire

// >>> dv/tb_top.sv
// testbench joining host and device ends across the link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// arbitrary address value
	localparam logic [63:0] A64 = 64'h0a1b2c3d4e5f6071;
	logic        clk_sys_i = 1'h0;
	logic        rst_i = 1'h1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_we = 1'h0;
	logic        reg_re = 1'h0;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        fwd_valid;
	logic [7:0]  fwd_fid, fwd_opt;
	logic        fwd_hp, rsp_rdy;
	logic [31:0] fwd_par;
	logic [15:0] fwd_cmd;
	logic [63:0] fwd_a64;
	logic        rsp_valid = 1'h0;
	logic        unreach = 1'h0;
	logic [7:0]  rsp_fid = 8'h00;
	logic [7:0]  rsp_st = 8'h00;
	logic [15:0] rsp_cmd = 16'h0;
	logic        rq_valid = 1'h0;
	logic        rq_hp = 1'h0;
	logic [7:0]  rq_fid = 8'h00;
	logic [7:0]  rq_opt = 8'h00;
	logic [15:0] rq_cmd = 16'h0;
	logic [31:0] rq_par = 32'h0;
	logic        rs_valid;
	logic        rs_hv;
	logic [7:0]  rs_fid;
	logic [7:0]  rs_st;
	logic [31:0] rs_val;
	logic [31:0] baud;
	logic [7:0]  rxq[$];
	int          mismatches = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          fwd_cnt = 0;

	rcf_link_if rcf_link_if_inst ();
	rcf_host rcf_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.lnk(rcf_link_if_inst), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
		.reg_rdata_o(reg_rdata), .irq_o(irq));
	rcf_device rcf_device_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.lnk(rcf_link_if_inst), .fwd_valid_o(fwd_valid),
		.fwd_addr64_o(fwd_a64), .fwd_fid_o(fwd_fid), .fwd_opt_o(fwd_opt),
		.fwd_cmd_o(fwd_cmd), .fwd_has_param_o(fwd_hp), .fwd_param_o(fwd_par),
		.rsp_valid_i(rsp_valid), .rsp_fid_i(rsp_fid), .rsp_addr64_i(A64),
		.rsp_addr16_i(16'h127e), .rsp_cmd_i(rsp_cmd),
		.rsp_status_i(rsp_st), .rsp_val_i(32'h0000002f),
		.unreach_i(unreach), .rsp_ready_o(rsp_rdy), .rreq_valid_i(rq_valid),
		.rreq_fid_i(rq_fid), .rreq_opt_i(rq_opt), .rreq_cmd_i(rq_cmd),
		.rreq_has_param_i(rq_hp), .rreq_param_i(rq_par),
		.rrsp_valid_o(rs_valid), .rrsp_fid_o(rs_fid),
		.rrsp_status_o(rs_st), .rrsp_has_val_o(rs_hv),
		.rrsp_val_o(rs_val), .serial_baud_setting_o(baud));
	rcf_link_sva rcf_link_sva_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.req_valid(rcf_link_if_inst.req_valid),
		.req_fid(rcf_link_if_inst.req_fid),
		.tx_valid(rcf_link_if_inst.tx_valid),
		.tx_byte(rcf_link_if_inst.tx_byte));

	////////////////////////////////////////////////////////////
	// clock, frame collector and forward counter on the quiet edge
	always #25 clk_sys_i = ~clk_sys_i;
	always @(negedge clk_sys_i)
	begin
		if (rcf_link_if_inst.tx_valid === 1'h1)
			rxq.push_back(rcf_link_if_inst.tx_byte);
		if (fwd_valid === 1'h1)
			fwd_cnt++;
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] s, e);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	// extra edge after each strobe so no signal is set twice per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'h1;
		@(posedge clk_sys_i);
		reg_we <= 1'h0;
		@(posedge clk_sys_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input string n);
		reg_addr <= a;
		reg_re <= 1'h1;
		@(posedge clk_sys_i);
		reg_re <= 1'h0;
		#1 chk(n, reg_rdata, e);
		@(posedge clk_sys_i);
	endtask : rd
	task automatic req(input logic [7:0] f, input logic [15:0] c,
			input logic hp);
		wr(rcf_pkg::REG_ADDR_HI, A64[63:32]);
		wr(rcf_pkg::REG_ADDR_LO, A64[31:0]);
		wr(rcf_pkg::REG_CMD, {f, 8'h00, c});
		wr(rcf_pkg::REG_PARAM, 32'h5);
		wr(rcf_pkg::REG_GO, {30'h0, hp, 1'h1});
		#1 chk("fwd", {fwd_valid, fwd_hp, fwd_cmd}, {1'h1, hp, c});
		chk("fwd par", {fwd_fid, fwd_opt, fwd_par}, {f, 8'h0, 32'h5});
		chk("fwd addr", fwd_a64, A64);
		@(posedge clk_sys_i);
	endtask : req
	// expected bytes built here, then the collected frame compared
	task automatic frame(input logic [7:0] f, st,
			input logic [15:0] a16, c, input int nv);
		logic [151:0] b;
		logic [7:0]   e[$];
		logic [7:0]   s;
		b = {rcf_pkg::TYPE_RSP, f, A64, a16, c, st, 32'h0000002f};
		e = {rcf_pkg::START_MARK, 8'h00, 8'(15 + nv)};
		s = 8'hff;
		for (int i = 0; i < 15 + nv; i++)
		begin
			e.push_back(b[151 - 8 * i -: 8]);
			s = s - b[151 - 8 * i -: 8];
		end
		e.push_back(s);
		for (int i = 0; i < 60 && rxq.size() < e.size(); i++)
			@(posedge clk_sys_i);
		repeat (4) @(posedge clk_sys_i);
		chk("frame size", rxq.size(), e.size());
		foreach (e[k])
			chk("frame byte", rxq[k], e[k]);
		rxq.delete();
	endtask : frame
	task automatic rsp(input logic [7:0] f, st, input logic [15:0] c,
			input int nv);
		chk("ready", rsp_rdy, 1'h1);
		rsp_fid <= f;
		rsp_st <= st;
		rsp_cmd <= c;
		rsp_valid <= 1'h1;
		@(posedge clk_sys_i);
		rsp_valid <= 1'h0;
		frame(f, st, 16'h127e, c, nv);
	endtask : rsp
	task automatic nreq(input logic [7:0] f, o, input logic [15:0] c,
			input logic hp, input logic [31:0] p, input logic [7:0] st,
			input logic hv, input logic [31:0] b);
		rq_fid <= f;
		rq_opt <= o;
		rq_cmd <= c;
		rq_hp <= hp;
		rq_par <= p;
		rq_valid <= 1'h1;
		@(posedge clk_sys_i);
		rq_valid <= 1'h0;
		#1 chk("node valid", rs_valid, f != 8'h00);
		if (f != 8'h00)
			chk("node rsp", {rs_fid, rs_st, rs_hv}, {f, st, hv});
		if (hv)
			chk("node value", rs_val, b);
		chk("baud", baud, b);
		@(posedge clk_sys_i);
	endtask : nreq

	////////////////////////////////////////////////////////////
	task automatic t_query;
		req(8'h27, 16'h5450, 1'h0);
		rsp(8'h27, rcf_pkg::ST_OK, 16'h5450, 4);
		rd(rcf_pkg::REG_RSP_INFO, 32'h27005450, "rsp info");
		rd(rcf_pkg::REG_RSP_VAL, 32'h2f, "rsp value");
		rd(rcf_pkg::REG_IRQ_STAT, 32'h1, "irq status");
		wr(rcf_pkg::REG_IRQ_CLR, 32'h7);
		rd(rcf_pkg::REG_IRQ_STAT, 32'h0, "irq cleared");
		rd(8'h30, 32'h0, "unmapped");
		$display("query test done");
	endtask : t_query
	task automatic t_change;
		logic [7:0] sts [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
			8'h04, 8'h0b, 8'h0c, 8'h0d};
		int n;
		req(8'h28, 16'h4244, 1'h1);
		foreach (sts[i])
		begin
			n = fwd_cnt;
			rsp(8'h28, sts[i], 16'h4244, 0);
			chk("retry", fwd_cnt - n, sts[i] == 8'h04);
		end
		$display("change test done");
	endtask : t_change
	task automatic t_unreach;
		int n;
		wr(rcf_pkg::REG_IRQ_CLR, 32'h7);
		wr(rcf_pkg::REG_IRQ_EN, 32'h2);
		req(8'h00, 16'h4944, 1'h1);
		unreach <= 1'h1;
		@(posedge clk_sys_i);
		unreach <= 1'h0;
		repeat (40) @(posedge clk_sys_i);
		chk("silent", rxq.size(), 0);
		req(8'h29, 16'h4944, 1'h1);
		n = fwd_cnt;
		unreach <= 1'h1;
		@(posedge clk_sys_i);
		unreach <= 1'h0;
		frame(8'h29, rcf_pkg::ST_TX_FAIL, 16'hfffe, 16'h4944, 0);
		chk("retry", fwd_cnt - n, 1);
		chk("irq", irq, 1'h1);
		wr(rcf_pkg::REG_IRQ_EN, 32'h0);
		@(posedge clk_sys_i);
		chk("irq masked", irq, 1'h0);
		wr(rcf_pkg::REG_IRQ_EN, 32'h2);
		wr(rcf_pkg::REG_IRQ_CLR, 32'h2);
		@(posedge clk_sys_i);
		chk("irq clear", irq, 1'h0);
		$display("unreach test done");
	endtask : t_unreach
	task automatic t_node;
		nreq(8'h00, 8'h00, 16'h4244, 1'h1, 32'h7, 8'h0, 1'h0, 32'h3);
		nreq(8'h05, 8'h00, 16'h4244, 1'h1, 32'h7, 8'h0, 1'h0, 32'h3);
		nreq(8'h06, 8'h00, 16'h4244, 1'h0, 32'h0, 8'h0, 1'h1, 32'h3);
		nreq(8'h07, 8'h00, 16'h4143, 1'h0, 32'h0, 8'h0, 1'h0, 32'h7);
		nreq(8'h08, 8'h02, 16'h4244, 1'h1, 32'h9, 8'h0, 1'h0, 32'h9);
		nreq(8'h09, 8'h00, 16'h4244, 1'h1, 32'h4, 8'h0, 1'h0, 32'h9);
		nreq(8'h0a, 8'h00, 16'h5752, 1'h0, 32'h0, 8'h0, 1'h0, 32'h9);
		nreq(8'h0b, 8'h00, 16'h4652, 1'h0, 32'h0, 8'h0, 1'h0, 32'h4);
		nreq(8'h0c, 8'h00, 16'h5450, 1'h0, 32'h0, 8'h2, 1'h0, 32'h4);
		$display("node test done");
	endtask : t_node

	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		@(posedge clk_sys_i);
		t_query();
		t_change();
		t_unreach();
		t_node();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
